/* File: src/adr_device.sv */
// converter end: conversion timing, mode capture and serial result shifter
`timescale 1ns/1ps
module adr_device (
   input  wire logic                                mclk_i,
   input  wire logic                                srst_i,
   input  wire logic signed [adr_pkg::RAW_W-1:0]    sample_i,
   output logic                                     conv_busy_o,
   output logic [adr_pkg::WORD_W-1:0]               result_o,
   output logic                                     result_valid_o,
   output logic                                     busy_ind_o,
   adr_if.dev                                       link
);
   import adr_pkg::*;

   typedef enum logic [1:0]
   {
      ADR_DST_IDLE = 2'b01,
      ADR_DST_CONV = 2'b10
   } adr_dev_st_e;

   logic [SYNC_LAT-1:0]     cnv_sync_ff;
   logic [SYNC_LAT-1:0]     sdi_sync_ff;
   logic                    cnv_lvl_ff;
   logic                    sdi_lvl_ff;
   adr_dev_st_e             st_ff;
   logic                    chain_mode_ff;
   logic [TMR_W-1:0]        conv_cnt_ff;
   logic signed [RAW_W-1:0] raw_ff;
   logic [WORD_W-1:0]       result_ff;
   logic                    res_valid_ff;
   logic                    result_valid_ff;
   logic                    busy_ind_ff;
   logic                    rd_en_ff;
   logic                    oe_ff;
   logic [CNT_W-1:0]        bit_cnt_ff;
   logic [WORD_W-1:0]       chain_sr_ff;
   logic                    cnv_rise;
   logic                    sdi_now;
   logic                    select_lvl;
   logic                    conv_end;
   logic                    stream_bit;

   // pins are asynchronous to mclk_i
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         cnv_sync_ff <= '0;
         // idle level of the pin, so no false level follows reset
         sdi_sync_ff <= '1;
      end
      else
      begin
         cnv_sync_ff <= {cnv_sync_ff[SYNC_LAT-2:0], link.convert_start_in};
         sdi_sync_ff <= {sdi_sync_ff[SYNC_LAT-2:0], link.serial_chain_in};
      end
   end

   // a level counts once the last two stages agree
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         cnv_lvl_ff <= 1'b0;
         sdi_lvl_ff <= 1'b1;
      end
      else
      begin
         if (cnv_sync_ff[SYNC_LAT-1] == cnv_sync_ff[SYNC_LAT-2])
         begin
            cnv_lvl_ff <= cnv_sync_ff[SYNC_LAT-1];
         end
         if (sdi_sync_ff[SYNC_LAT-1] == sdi_sync_ff[SYNC_LAT-2])
         begin
            sdi_lvl_ff <= sdi_sync_ff[SYNC_LAT-1];
         end
      end
   end

   assign cnv_rise = cnv_sync_ff[SYNC_LAT-1] & cnv_sync_ff[SYNC_LAT-2] & ~cnv_lvl_ff;
   assign sdi_now  = (sdi_sync_ff[SYNC_LAT-1] == sdi_sync_ff[SYNC_LAT-2])
                     ? sdi_sync_ff[SYNC_LAT-1] : sdi_lvl_ff;

   // chain reads while convert is high; gated mode selects on either low
   assign select_lvl = chain_mode_ff ? cnv_lvl_ff
                                     : (~cnv_lvl_ff | ~sdi_lvl_ff);

   assign conv_end = (st_ff == ADR_DST_CONV) &&
                     (conv_cnt_ff == TMR_W'(DEV_CONV_CYC - 1));

   // an edge during conversion is ignored, the sample would be torn
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st_ff <= ADR_DST_IDLE;
      end
      else
      begin
         case (st_ff)
            ADR_DST_IDLE:
            begin
               if (cnv_rise)
               begin
                  st_ff <= ADR_DST_CONV;
               end
            end
            ADR_DST_CONV:
            begin
               if (conv_end)
               begin
                  st_ff <= ADR_DST_IDLE;
               end
            end
            default:
            begin
               st_ff <= ADR_DST_IDLE;
            end
         endcase
      end
   end

   // conversion timed on mclk_i alone, serial clock not needed
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         conv_cnt_ff <= '0;
      end
      else if (st_ff == ADR_DST_IDLE)
      begin
         conv_cnt_ff <= '0;
      end
      else
      begin
         conv_cnt_ff <= conv_cnt_ff + 1'b1;
      end
   end

   // mode and sample are taken at the same edge
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         chain_mode_ff <= 1'b0;
         raw_ff        <= '0;
      end
      else if (cnv_rise && st_ff == ADR_DST_IDLE)
      begin
         chain_mode_ff <= ~sdi_now;
         raw_ff        <= sample_i;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         result_ff       <= '0;
         res_valid_ff    <= 1'b0;
         result_valid_ff <= 1'b0;
      end
      else
      begin
         result_valid_ff <= conv_end;
         if (conv_end)
         begin
            result_ff    <= adr_clip(raw_ff);
            res_valid_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         busy_ind_ff <= 1'b0;
      end
      else if (conv_end)
      begin
         busy_ind_ff <= ~chain_mode_ff & select_lvl;
      end
   end

   // rd_en_ff low holds the link-side shifter cleared between frames
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         rd_en_ff <= 1'b0;
         oe_ff    <= 1'b0;
      end
      else
      begin
         rd_en_ff <= select_lvl & res_valid_ff & ~cnv_rise & (st_ff == ADR_DST_IDLE);
         if (chain_mode_ff)
         begin
            oe_ff <= cnv_lvl_ff & res_valid_ff & (st_ff == ADR_DST_IDLE);
         end
         else
         begin
            oe_ff <= select_lvl;
         end
      end
   end

   // link side: advances on the falling serial clock edge only
   always_ff @(negedge link.sck or negedge rd_en_ff)
   begin
      if (!rd_en_ff)
      begin
         bit_cnt_ff  <= '0;
         chain_sr_ff <= '0;
      end
      else
      begin
         if (bit_cnt_ff != CHAIN_DELAY)
         begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
         end
         chain_sr_ff <= {chain_sr_ff[WORD_W-2:0], link.serial_chain_in};
      end
   end

   // in chain mode the upstream bits follow the own word, 16 clocks late; gated mode sends zeros after it
   always_comb
   begin
      if (bit_cnt_ff == CHAIN_DELAY)
      begin
         stream_bit = chain_mode_ff & chain_sr_ff[WORD_W-1];
      end
      else
      begin
         stream_bit = adr_word_bit(result_ff, bit_cnt_ff);
      end
   end

   // low while converting acts as the busy mark on the output
   assign link.sdo_o  = (st_ff == ADR_DST_CONV) ? 1'b0 : stream_bit;
   assign link.sdo_oe = oe_ff;

   assign conv_busy_o    = (st_ff == ADR_DST_CONV);
   assign result_o       = result_ff;
   assign result_valid_o = result_valid_ff;
   assign busy_ind_o     = busy_ind_ff;
endmodule : adr_device

/* File: src/adr_host.sv */
// host end: conversion sequencer, serial clock divider and result fifo
`timescale 1ns/1ps
module adr_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         mclk_i,
   input  wire logic         srst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0]   count_ff;
   logic          do_wr;
   logic          do_rd;

   function automatic logic [AW-1:0] adr_ptr_next(input logic [AW-1:0] p);
      return (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction : adr_ptr_next

   assign in_ready_o  = (count_ff != (AW+1)'(D));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o  = mem_ff[rd_ptr_ff];
   assign do_wr       = in_valid_i & in_ready_o;
   assign do_rd       = out_valid_o & out_ready_i;

   always_ff @(posedge mclk_i)
   begin
      if (do_wr)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end
      else
      begin
         if (do_wr)
         begin
            wr_ptr_ff <= adr_ptr_next(wr_ptr_ff);
         end
         if (do_rd)
         begin
            rd_ptr_ff <= adr_ptr_next(rd_ptr_ff);
         end
         count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule : adr_fifo

module adr_host (
   input  wire logic                  mclk_i,
   input  wire logic                  srst_i,
   input  wire logic                  start_i,
   input  wire logic                  chain_mode_i,
   output logic                       start_ready_o,
   output logic [adr_pkg::WORD_W-1:0] word_o,
   output logic                       word_valid_o,
   input  wire logic                  word_ready_i,
   adr_if.host                        link
);
   import adr_pkg::*;

   typedef enum logic [5:0]
   {
      ADR_HST_IDLE  = 6'b000001,
      ADR_HST_SETUP = 6'b000010,
      ADR_HST_RISE  = 6'b000100,
      ADR_HST_WAIT  = 6'b001000,
      ADR_HST_SHIFT = 6'b010000,
      ADR_HST_PUSH  = 6'b100000
   } adr_host_st_e;

   adr_host_st_e      st_ff;
   logic [TMR_W-1:0]  tmr_ff;
   logic [CNT_W-1:0]  bits_ff;
   logic [WORD_W-1:0] word_sr_ff;
   logic              chain_ff;
   logic              cnv_ff;
   logic              sdi_ff;
   logic              sck_ff;
   logic [SYNC_LAT-1:0] sdo_sync_ff;
   logic              sdo_lvl_ff;
   logic              fifo_ready;
   logic              half_end;

   adr_fifo #(
      .W (WORD_W),
      .D (FIFO_DEPTH)
   ) adr_fifo_i (
      .mclk_i      (mclk_i),
      .srst_i      (srst_i),
      .in_valid_i  (st_ff == ADR_HST_PUSH),
      .in_ready_o  (fifo_ready),
      .in_data_i   (word_sr_ff),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i),
      .out_data_o  (word_o)
   );

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         sdo_sync_ff <= '0;
         sdo_lvl_ff  <= 1'b0;
      end
      else
      begin
         sdo_sync_ff <= {sdo_sync_ff[SYNC_LAT-2:0], link.serial_result_out};
         if (sdo_sync_ff[SYNC_LAT-1] == sdo_sync_ff[SYNC_LAT-2])
         begin
            sdo_lvl_ff <= sdo_sync_ff[SYNC_LAT-1];
         end
      end
   end

   assign half_end      = (tmr_ff == TMR_W'(SCK_HALF_CYC - 1));
   // a full fifo stalls new conversions
   assign start_ready_o = (st_ff == ADR_HST_IDLE) & fifo_ready;

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st_ff      <= ADR_HST_IDLE;
         tmr_ff     <= '0;
         bits_ff    <= '0;
         word_sr_ff <= '0;
         chain_ff   <= 1'b0;
         cnv_ff     <= 1'b0;
         sdi_ff     <= 1'b1;
         sck_ff     <= 1'b0;
      end
      else
      begin
         tmr_ff <= tmr_ff + 1'b1;
         case (st_ff)
            ADR_HST_IDLE:
            begin
               tmr_ff <= '0;
               if (start_i && start_ready_o)
               begin
                  chain_ff <= chain_mode_i;
                  sdi_ff   <= ~chain_mode_i;
                  st_ff    <= ADR_HST_SETUP;
               end
            end
            ADR_HST_SETUP:
            begin
               if (tmr_ff == TMR_W'(HOST_SETUP_CYC - 1))
               begin
                  cnv_ff <= 1'b1;
                  tmr_ff <= '0;
                  st_ff  <= ADR_HST_RISE;
               end
            end
            ADR_HST_RISE:
            begin
               if (tmr_ff == TMR_W'(CNV_HOLD_CYC - 1))
               begin
                  cnv_ff <= chain_ff;
                  sdi_ff <= ~chain_ff;
                  tmr_ff <= '0;
                  st_ff  <= ADR_HST_WAIT;
               end
            end
            ADR_HST_WAIT:
            begin
               if (tmr_ff == TMR_W'(HOST_WAIT_CYC - 1))
               begin
                  tmr_ff  <= '0;
                  bits_ff <= '0;
                  st_ff   <= ADR_HST_SHIFT;
               end
            end
            ADR_HST_SHIFT:
            begin
               if (half_end)
               begin
                  tmr_ff <= '0;
                  sck_ff <= ~sck_ff;
                  if (!sck_ff)
                  begin
                     word_sr_ff <= {word_sr_ff[WORD_W-2:0], sdo_lvl_ff};
                     bits_ff    <= bits_ff + 1'b1;
                     // stands in for an upstream part; changes on the rise,
                     // so the chain input is steady at the falling edge
                     if (chain_ff)
                     begin
                        sdi_ff <= word_sr_ff[WORD_W-1];
                     end
                  end
                  else if (bits_ff == CNT_W'(WORD_W))
                  begin
                     st_ff <= ADR_HST_PUSH;
                  end
               end
            end
            ADR_HST_PUSH:
            begin
               if (fifo_ready)
               begin
                  cnv_ff <= 1'b0;
                  sdi_ff <= 1'b1;
                  st_ff  <= ADR_HST_IDLE;
               end
            end
            default:
            begin
               st_ff <= ADR_HST_IDLE;
            end
         endcase
      end
   end

   assign link.convert_start_in = cnv_ff;
   assign link.serial_chain_in = sdi_ff;
   assign link.sck = sck_ff;
endmodule : adr_host

/* File: src/adr_if.sv */
// pin bundle between the converter end and the host end
`timescale 1ns/1ps
interface adr_if;
   logic convert_start_in;
   logic sck;
   logic serial_chain_in;
   logic sdo_o;
   logic sdo_oe;
   wire  serial_result_out;

   // released line settles high, as through a pull-up
   assign serial_result_out = sdo_oe ? sdo_o : 1'b1;

   modport dev (
      input  convert_start_in,
      input  sck,
      input  serial_chain_in,
      output sdo_o,
      output sdo_oe
   );

   modport host (
      output convert_start_in,
      output sck,
      output serial_chain_in,
      input  serial_result_out
   );
endinterface : adr_if

/* File: src/adr_pkg.sv */
// shared constants, clipping and bit selection for the converter readout link
package adr_pkg;
   localparam int WORD_W         = 16;
   localparam int RAW_W          = 18;
   localparam int CNT_W          = 5;
   localparam int SYNC_LAT       = 3;
   localparam int MCLK_PERIOD_NS = 100;
   localparam int CONV_TIME_NS   = 1600;
   // longest time, so the cycle count rounds down
   localparam int CONV_CYC       = CONV_TIME_NS / MCLK_PERIOD_NS;
   // the device spends part of the budget on its input synchroniser
   localparam int DEV_CONV_CYC   = CONV_CYC - SYNC_LAT - 1;
   localparam int HOST_WAIT_CYC  = CONV_CYC + 2 * SYNC_LAT + 2;
   localparam int HOST_SETUP_CYC = SYNC_LAT + 2;
   localparam int CNV_HOLD_CYC   = SYNC_LAT + 2;
   localparam int SCK_HALF_CYC   = 6;
   localparam int TMR_W          = 8;
   localparam int FIFO_DEPTH     = 8;
   localparam logic [CNT_W-1:0]  CHAIN_DELAY = 5'h10;
   localparam logic [WORD_W-1:0] CODE_MAX    = 16'h7fff;
   localparam logic [WORD_W-1:0] CODE_MIN    = 16'h8000;
   localparam logic signed [RAW_W-1:0] RAW_MAX = 18'sh0_7fff;
   localparam logic signed [RAW_W-1:0] RAW_MIN = -18'sh0_8000;

   function automatic logic [WORD_W-1:0] adr_clip(input logic signed [RAW_W-1:0] raw);
      logic [WORD_W-1:0] code;
      code = raw[WORD_W-1:0];
      if (raw > RAW_MAX)
      begin
         code = CODE_MAX;
      end
      else if (raw < RAW_MIN)
      begin
         code = CODE_MIN;
      end
      return code;
   endfunction : adr_clip

   // msb first: position 0 is bit 15
   function automatic logic adr_word_bit(input logic [WORD_W-1:0] word,
                                         input logic [CNT_W-1:0]  pos);
      logic [CNT_W-1:0] idx;
      idx = CNT_W'(WORD_W - 1) - pos;
      return word[idx[$clog2(WORD_W)-1:0]];
   endfunction : adr_word_bit
endpackage : adr_pkg

/* File: test/adc_serial_readout_modes_tb_top.sv */
// self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ps
module adc_serial_readout_modes_tb_top;
   import adr_pkg::*;
   logic               mclk_i, srst_i, start_i, chain_mode_i, word_ready_i;
   logic               start_ready_o, word_valid_o, conv_busy_o, result_valid_o, busy_ind_o;
   logic [15:0]        word_o, result_o;
   logic signed [17:0] sample_i;
   logic signed [17:0] tbl [6] = '{18'h0_1234, 18'h1_0000, 18'h3_7fff,
                                   18'h0_7fff, 18'h3_8000, 18'h3_fffe};
   int                 errors, comparisons, n;

   adr_if adr_if_i ();
   adr_device adr_device_i (.mclk_i(mclk_i), .srst_i(srst_i), .sample_i(sample_i),
      .conv_busy_o(conv_busy_o), .result_o(result_o), .result_valid_o(result_valid_o),
      .busy_ind_o(busy_ind_o), .link(adr_if_i));
   adr_host adr_host_i (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i),
      .chain_mode_i(chain_mode_i), .start_ready_o(start_ready_o), .word_o(word_o),
      .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .link(adr_if_i));
   adr_link_assertions adr_link_assertions_i (.mclk_i(mclk_i), .srst_i(srst_i),
      .convert_start_in(adr_if_i.convert_start_in), .sck(adr_if_i.sck), .serial_chain_in(adr_if_i.serial_chain_in),
      .sdo_o(adr_if_i.sdo_o), .sdo_oe(adr_if_i.sdo_oe));

   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end

   task give_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   task tick;
      @(negedge mclk_i);
   endtask : tick

   task check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check_word

   task check_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   function automatic logic pick(input string w);
      case (w)
         "ready": return start_ready_o;
         "word":  return word_valid_o;
         "valid": return result_valid_o;
         default: return adr_if_i.convert_start_in;
      endcase
   endfunction : pick

   // bounded wait; running out ends the run as a failure
   task wait_hi(input string w, input int lim);
      n = 0;
      while (pick(w) !== 1'b1 && n < lim)
      begin
         tick();
         n++;
      end
      if (n >= lim)
      begin
         errors++;
         $display("MISMATCH wait_%s expected 1 seen timeout", w);
         give_verdict();
      end
   endtask : wait_hi

   function automatic logic [15:0] exp_code(input logic signed [17:0] raw);
      if (raw > 18'sh0_7fff)
         return 16'h7fff;
      if (raw < -18'sh0_8000)
         return 16'h8000;
      return raw[15:0];
   endfunction : exp_code

   task start_conv(input logic signed [17:0] s, input logic chain);
      wait_hi("ready", 600);
      sample_i     = s;
      chain_mode_i = chain;
      start_i      = 1'b1;
      tick();
      start_i      = 1'b0;
   endtask : start_conv

   task conv_time(input logic [15:0] exp);
      wait_hi("cnv", 20);
      repeat (SYNC_LAT + 2) tick();
      check_bit("conv_busy", 1'b1, conv_busy_o);
      wait_hi("valid", 40);
      check_bit("conv_time", 1'b1, n <= CONV_CYC - SYNC_LAT - 2);
      check_bit("conv_done", 1'b0, conv_busy_o);
      check_word("result", exp, result_o);
   endtask : conv_time

   task take_word(input logic [15:0] exp);
      wait_hi("word", 400);
      check_word("word", exp, word_o);
      word_ready_i = 1'b1;
      tick();
      word_ready_i = 1'b0;
      tick();
   endtask : take_word

   task test_modes;
      for (int i = 0; i < 6; i++)
      begin
         start_conv(tbl[i], i[0]);
         conv_time(exp_code(tbl[i]));
         take_word(exp_code(tbl[i]));
         check_bit("busy_ind", !i[0], busy_ind_o);
      end
      $display("test modes done");
   endtask : test_modes

   // fill the result buffer with nobody popping, then drain in order
   task test_fifo;
      for (int i = 0; i < 8; i++)
      begin
         start_conv(tbl[i % 6], i[1]);
         conv_time(exp_code(tbl[i % 6]));
      end
      repeat (300) tick();
      check_bit("start_ready_full", 1'b0, start_ready_o);
      start_i = 1'b1;
      tick();
      start_i = 1'b0;
      for (int i = 0; i < 8; i++)
         take_word(exp_code(tbl[i % 6]));
      tick();
      check_bit("word_valid_empty", 1'b0, word_valid_o);
      check_bit("start_ready_empty", 1'b1, start_ready_o);
      $display("test fifo done");
   endtask : test_fifo

   task test_reset;
      start_conv(18'h0_0042, 1'b0);
      wait_hi("cnv", 20);
      srst_i = 1'b1;
      repeat (3) tick();
      check_bit("oe_in_reset", 1'b0, adr_if_i.sdo_oe);
      check_bit("word_in_reset", 1'b0, word_valid_o);
      srst_i = 1'b0;
      start_conv(18'h0_00a5, 1'b1);
      conv_time(16'h00a5);
      take_word(16'h00a5);
      $display("test reset done");
   endtask : test_reset

   initial
   begin
      errors       = 0;
      comparisons  = 0;
      srst_i       = 1'b1;
      start_i      = 1'b0;
      chain_mode_i = 1'b0;
      word_ready_i = 1'b0;
      sample_i     = 18'h0_0000;
      repeat (10) tick();
      srst_i = 1'b0;
      test_modes();
      test_fifo();
      test_reset();
      give_verdict();
   end

   initial
   begin
      repeat (100000) @(posedge mclk_i);
      errors++;
      $display("MISMATCH run_length expected finish seen timeout");
      give_verdict();
   end
endmodule : adc_serial_readout_modes_tb_top

/* File: test/adr_link_assertions.sv */
// pin-level checker for the converter readout link
`timescale 1ns/1ps
module adr_link_assertions (
   input  wire logic mclk_i,
   input  wire logic srst_i,
   input  wire logic convert_start_in,
   input  wire logic sck,
   input  wire logic serial_chain_in,
   input  wire logic sdo_o,
   input  wire logic sdo_oe
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   logic        gated_ff;
   logic        cnv_q_ff;
   logic        sck_q_ff;
   logic [4:0]  falls_ff;
   logic [15:0] hist_ff;

   always_ff @(posedge mclk_i)
   begin
      cnv_q_ff <= srst_i ? 1'b0 : convert_start_in;
      sck_q_ff <= srst_i ? 1'b0 : sck;
   end

   // mode taken at the pin edge, ahead of the device synchroniser
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         gated_ff <= 1'b1;
      else if (convert_start_in && !cnv_q_ff)
         gated_ff <= serial_chain_in;
   end

   // saturating count of serial clock falls since the convert edge
   always_ff @(posedge mclk_i)
   begin
      if (srst_i || (convert_start_in && !cnv_q_ff))
         falls_ff <= 5'h0;
      else if (sck_q_ff && !sck && falls_ff != 5'h1f)
         falls_ff <= falls_ff + 5'h1;
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         hist_ff <= 16'h0000;
      else if (sck_q_ff && !sck)
         hist_ff <= {hist_ff[14:0], serial_chain_in};
   end

   gated_enable_a: assert property ((gated_ff && !(convert_start_in && serial_chain_in))[*8] |-> sdo_oe)
      else $error("gated mode output not enabled while a select is low");
   gated_open_a: assert property (gated_ff && !convert_start_in && cnv_q_ff |-> ##[1:8] sdo_oe)
      else $error("gated mode output not enabled after convert fell");
   gated_shift_a: assert property (gated_ff && !convert_start_in && sck |-> sdo_oe)
      else $error("gated mode output off during shifting");
   chain_shift_a: assert property (!gated_ff && convert_start_in && sck |-> sdo_oe)
      else $error("chain mode output off during readout");
   chain_idle_a: assert property (!gated_ff && (!convert_start_in)[*8] |-> !sdo_oe)
      else $error("chain mode output driven with convert low");
   shift_hold_a: assert property (sck && $past(sck) && sdo_oe && $past(sdo_oe) |-> $stable(sdo_o))
      else $error("serial output moved away from a serial clock fall");
   chain_pass_a: assert property (!gated_ff && !sck && falls_ff >= 5'h10 && sdo_oe
                                  |-> sdo_o == hist_ff[15])
      else $error("chain input not passed through after sixteen clocks");
   conv_quiet_a: assert property (convert_start_in && !cnv_q_ff |=> (!sck)[*8])
      else $error("serial clock active during conversion");

   cover property (gated_ff && sck);
   cover property (!gated_ff && sck);
   cover property (!gated_ff && falls_ff >= 5'h10 && sdo_oe);
endmodule : adr_link_assertions
